// [hdl/isf_cfg.svh]
// constants for the input select and format stage
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define ISF_BUS_W 17
`define ISF_MANT_W 16
`define ISF_EXP_W 3
`define ISF_N_BUS 4
`define ISF_BUS_SEL_W 2
`define ISF_N_INST 5
`define ISF_LVL_INST 4
`define ISF_N_SYNC 5
`define ISF_SRC_W 3
`define ISF_DLY_W 3
`define ISF_DLY_TAPS 8

// -----------------------------------------------------------------
// source codes and bus bit positions
// -----------------------------------------------------------------
`define ISF_SRC_TEST 3'h4
`define ISF_RAW_SIGN 16
`define ISF_FIX_LO 1
`define ISF_F3_LO 4
`define ISF_F2_LO 3
`define ISF_EXP_LO 1
`define ISF_EXT_BIT 0

`endif

// [hdl/isf_pkg.sv]
// types shared by the input select and format stage
`default_nettype none

`include "isf_cfg.svh"

package isf_pkg;

  // -----------------------------------------------------------------
  // sample formats
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    ISF_FMT_FIXED = 2'b00,
    ISF_FMT_FLT3 = 2'b01,
    ISF_FMT_FLT2 = 2'b10,
    ISF_FMT_FLT3X = 2'b11
  } isf_fmt_t;

  typedef struct packed {
    logic [`ISF_SRC_W-1:0] src;
    logic interp;
    logic [`ISF_DLY_W-1:0] dly;
    logic offset_bin;
    isf_fmt_t fmt;
  } isf_cfg_t;

  typedef struct packed {
    logic valid;
    logic [`ISF_MANT_W-1:0] mant;
    logic [`ISF_EXP_W-1:0] expo;
  } isf_smp_t;

  // -----------------------------------------------------------------
  // state records
  // -----------------------------------------------------------------
  typedef struct packed {
    logic armed;
    logic en1;
    logic [`ISF_DLY_TAPS-2:0] dly;
    isf_smp_t in_s;
    isf_smp_t sel;
    isf_smp_t out;
  } isf_chan_st_t;

  typedef struct packed {
    isf_chan_st_t [`ISF_N_INST-1:0] ch;
  } isf_top_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } isf_sync_st_t;

endpackage

`default_nettype wire

// [hdl/isf_sync.sv]
// three-stage pin synchroniser with rising-edge pulse
`default_nettype none

`include "isf_cfg.svh"

module isf_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin and pulse
  input wire logic pin_in,
  output logic rise
);

  isf_pkg::isf_sync_st_t st_q;
  isf_pkg::isf_sync_st_t st_d;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // level moves only once the last two stages agree
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = st_q.s2 & st_q.s3 & ~st_q.lvl;

endmodule

`default_nettype wire

// [hdl/isf_top.sv]
// input select and format stage: four channels plus level detector
`default_nettype none

`include "isf_cfg.svh"

module isf_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // converter sample buses
  input wire logic [`ISF_N_BUS-1:0][`ISF_BUS_W-1:0] bus_data,
  input wire logic [`ISF_N_BUS-1:0] bus_input_enable_n,
  // host test source
  input wire logic [`ISF_BUS_W-1:0] test_data,
  input wire logic test_strobe,
  // sync pins
  input wire logic global_sync_in,
  input wire logic [`ISF_N_BUS-1:0] channel_sync_in,
  // per stage configuration
  input wire isf_pkg::isf_cfg_t [`ISF_N_INST-1:0] inst_cfg,
  // formatted samples and status
  output var isf_pkg::isf_smp_t [`ISF_N_INST-1:0] sample_out,
  output logic [`ISF_N_INST-1:0] input_armed
);

  isf_pkg::isf_top_st_t st_q;
  isf_pkg::isf_top_st_t st_d;

  logic [`ISF_N_SYNC-1:0] sync_pins;
  logic [`ISF_N_SYNC-1:0] sync_rise;
  logic [`ISF_N_INST-1:0][`ISF_BUS_W-1:0] raw_sel;
  logic [`ISF_N_INST-1:0] en_now;
  logic [`ISF_N_INST-1:0] en_gated;
  logic [`ISF_N_INST-1:0] interp_eff;
  logic [`ISF_N_INST-1:0] tap;
  logic [`ISF_N_INST-1:0] arm_pulse;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // -----------------------------------------------------------------
  // sample formatting
  // -----------------------------------------------------------------
  function automatic isf_pkg::isf_smp_t fmt_sample(input logic [`ISF_BUS_W-1:0] raw,
                                                   input isf_pkg::isf_cfg_t c);
    logic [`ISF_BUS_W-1:0] r;
    isf_pkg::isf_smp_t s;
    r = raw;
    r[`ISF_RAW_SIGN] = raw[`ISF_RAW_SIGN] ^ c.offset_bin;
    s.valid = 1'b1;
    case (c.fmt)
      isf_pkg::ISF_FMT_FLT3: begin
        s.mant = {r[`ISF_RAW_SIGN:`ISF_F3_LO], 3'h0};
        s.expo = r[`ISF_F3_LO-1:`ISF_EXP_LO];
      end
      isf_pkg::ISF_FMT_FLT2: begin
        s.mant = {r[`ISF_RAW_SIGN:`ISF_F2_LO], 2'h0};
        s.expo = {1'b0, r[`ISF_F2_LO-1:`ISF_EXP_LO]};
      end
      isf_pkg::ISF_FMT_FLT3X: begin
        s.mant = {r[`ISF_RAW_SIGN:`ISF_F2_LO], 2'h0};
        s.expo = {r[`ISF_EXT_BIT], r[`ISF_F2_LO-1:`ISF_EXP_LO]};
      end
      default: begin
        // msb weighs one, lsb one part in 2^15
        s.mant = r[`ISF_RAW_SIGN:`ISF_FIX_LO];
        s.expo = 3'h0;
      end
    endcase
    return s;
  endfunction

  // -----------------------------------------------------------------
  // sync pins
  // -----------------------------------------------------------------
  assign sync_pins = {channel_sync_in, global_sync_in};

  for (genvar j = 0; j < `ISF_N_SYNC; j++) begin : g_sync
    isf_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in(sync_pins[j]),
      .rise(sync_rise[j])
    );
  end

  // -----------------------------------------------------------------
  // per stage source pick and enables
  // -----------------------------------------------------------------
  for (genvar g = 0; g < `ISF_N_INST; g++) begin : g_inst
    logic use_test;
    logic [`ISF_BUS_SEL_W-1:0] bus_idx;
    logic [`ISF_DLY_TAPS-1:0] tap_vec;

    // each stage picks its own source
    assign use_test = inst_cfg[g].src >= `ISF_SRC_TEST;
    assign bus_idx = inst_cfg[g].src[`ISF_BUS_SEL_W-1:0];
    assign raw_sel[g] = use_test ? test_data : bus_data[bus_idx];
    assign en_now[g] = use_test ? test_strobe : ~bus_input_enable_n[bus_idx];
    assign en_gated[g] = en_now[g] & st_q.ch[g].armed;
    // gated until released
    assign interp_eff[g] = inst_cfg[g].interp & st_q.ch[g].armed;
    // delayed enable tap, zero is undelayed
    assign tap_vec = {st_q.ch[g].dly, st_q.ch[g].en1};
    assign tap[g] = tap_vec[inst_cfg[g].dly];
    if (g == `ISF_LVL_INST) begin : g_lvl
      assign arm_pulse[g] = sync_rise[0] | (|sync_rise[`ISF_N_SYNC-1:1]);
    end else begin : g_chan
      assign arm_pulse[g] = sync_rise[0] | sync_rise[g+1];
    end

    assign sample_out[g] = st_q.ch[g].out;
    assign input_armed[g] = st_q.ch[g].armed;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_arm;
      arm_pulse[g] |=> st_q.ch[g].armed;
    endproperty
    a_arm: assert property (p_arm) else $error("sync pulse did not arm stage");

    property p_hold_disarmed;
      !st_q.ch[g].armed && !arm_pulse[g] |=> !st_q.ch[g].armed && !sample_out[g].valid;
    endproperty
    a_hold_disarmed: assert property (p_hold_disarmed) else $error("stage armed without sync");

    property p_gated_one;
      !inst_cfg[g].interp && en_gated[g] ##1 !inst_cfg[g].interp |=> sample_out[g].valid;
    endproperty
    a_gated_one: assert property (p_gated_one) else $error("gated enable gave no sample");

    property p_gated_halt;
      !inst_cfg[g].interp && !en_gated[g] ##1 !inst_cfg[g].interp |=> !sample_out[g].valid;
    endproperty
    a_gated_halt: assert property (p_gated_halt) else $error("sample without enable in gated mode");

    property p_en_pipe;
      en_gated[g] |-> ##1 st_q.ch[g].en1 ##2 st_q.ch[g].dly[1];
    endproperty
    a_en_pipe: assert property (p_en_pipe) else $error("enable lost in pipeline");

    property p_interp_zero;
      inst_cfg[g].interp && st_q.ch[g].armed && !en_now[g]
        |=> st_q.ch[g].in_s.mant == '0 && st_q.ch[g].in_s.expo == '0;
    endproperty
    a_interp_zero: assert property (p_interp_zero) else $error("interpolated gap not zeroed");

    property p_interp_every;
      (inst_cfg[g].interp && st_q.ch[g].armed) [*3] |=> sample_out[g].valid;
    endproperty
    a_interp_every: assert property (p_interp_every) else $error("interpolated stream stalled");

    property p_mux_load;
      !interp_eff[g] && tap[g] |=> st_q.ch[g].sel.mant == $past(st_q.ch[g].in_s.mant);
    endproperty
    a_mux_load: assert property (p_mux_load) else $error("pick register missed delayed enable");

    property p_realign;
      !interp_eff[g] && st_q.ch[g].en1 |=> sample_out[g].mant == $past(st_q.ch[g].sel.mant);
    endproperty
    a_realign: assert property (p_realign) else $error("output not loaded on undelayed enable");

    property p_sign_fix;
      en_gated[g] && inst_cfg[g].fmt == isf_pkg::ISF_FMT_FIXED
        |=> st_q.ch[g].in_s.mant[`ISF_MANT_W-1] == ($past(raw_sel[g][`ISF_RAW_SIGN]) ^ $past(inst_cfg[g].offset_bin));
    endproperty
    a_sign_fix: assert property (p_sign_fix) else $error("offset binary sign not converted");

    c_arm: cover property ($rose(st_q.ch[g].armed));
    c_interp: cover property (interp_eff[g] && !en_now[g] ##1 interp_eff[g] && en_now[g]);
    c_mux_last: cover property (!interp_eff[g] && tap[g] && inst_cfg[g].dly == 3'h7);
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    isf_pkg::isf_chan_st_t c;
    isf_pkg::isf_chan_st_t n;
    c = '0;
    n = '0;
    st_d = st_q;
    for (int i = 0; i < `ISF_N_INST; i++) begin
      c = st_q.ch[i];
      n = c;
      // once released the inputs stay enabled
      n.armed = c.armed | arm_pulse[i];
      // enable follows the data
      n.en1 = en_gated[i];
      n.dly = {c.dly[`ISF_DLY_TAPS-3:0], c.en1};
      // word taken every clock so the delayed tap can pick any slot
      if (interp_eff[i] && !en_gated[i]) begin
        // zero stuffing
        n.in_s = '0;
        n.in_s.valid = 1'b1;
      end else begin
        n.in_s = fmt_sample(raw_sel[i], inst_cfg[i]);
        n.in_s.valid = en_gated[i] | interp_eff[i];
      end
      if (interp_eff[i]) begin
        n.sel = c.in_s;
        n.out = c.sel;
      end else begin
        if (tap[i]) begin
          n.sel = c.in_s;
        end
        if (c.en1) begin
          n.out = c.sel;
          n.out.valid = 1'b1;
        end else begin
          n.out.valid = 1'b0;
        end
      end
      st_d.ch[i] = n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

// [verif/isf_adc_model.sv]
// converter model driving the four sample buses
`default_nettype none

module isf_adc_model (
  // clock
  input wire logic sys_clk,
  // traffic: 0 idle, 1 every clock, 2 every other clock, 3 one clock in eight
  input wire logic [1:0] mode,
  input wire logic [16:0] base,
  // sample buses
  output logic [3:0][16:0] bus_data,
  output logic [3:0] bus_input_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] cnt;

  initial begin
    cnt = 3'h0;
    bus_data = '0;
    bus_input_enable_n = 4'hf;
  end

  // idle bus inverts every bit of its last word each clock
  always @(posedge sys_clk) begin
    #1;
    cnt = (mode == 2'h0) ? 3'h0 : cnt + 3'h1;
    for (int b = 0; b < 4; b++) begin
      bus_data[b] = (mode == 2'h0) ? ~bus_data[b] : base ^ {2'(b), cnt, 12'h000};
      case (mode)
        2'h1: bus_input_enable_n[b] = 1'b0;
        2'h2: bus_input_enable_n[b] = cnt[0];
        2'h3: bus_input_enable_n[b] = (cnt != 3'h0);
        default: bus_input_enable_n[b] = 1'b1;
      endcase
    end
  end
endmodule

`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the input select and format stage
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk, rst, test_strobe, global_sync_in;
  logic [3:0][16:0] bus_data;
  logic [3:0] bus_input_enable_n, channel_sync_in;
  logic [16:0] test_data, base;
  logic [1:0] mode;
  isf_pkg::isf_cfg_t [4:0] inst_cfg;
  isf_pkg::isf_smp_t [4:0] sample_out;
  logic [4:0] input_armed;
  isf_pkg::isf_smp_t got[$];
  int error_cnt = 0;
  int total_checks = 0;

  isf_top isf_top_i (.sys_clk(sys_clk), .rst(rst), .bus_data(bus_data), .bus_input_enable_n(bus_input_enable_n),
    .test_data(test_data), .test_strobe(test_strobe), .global_sync_in(global_sync_in),
    .channel_sync_in(channel_sync_in), .inst_cfg(inst_cfg), .sample_out(sample_out), .input_armed(input_armed));
  isf_adc_model isf_adc_model_i (.sys_clk(sys_clk), .mode(mode), .base(base), .bus_data(bus_data),
    .bus_input_enable_n(bus_input_enable_n));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [16:0] word(input int b, input int c);
    return base ^ {2'(b), 3'(c), 12'h000};
  endfunction

  function automatic isf_pkg::isf_smp_t fmt_exp(input logic [16:0] w, input logic [1:0] f, input logic ob);
    isf_pkg::isf_smp_t s;
    w[16] = w[16] ^ ob;
    s.valid = 1'b1;
    case (f)
      2'h0: begin s.mant = w[16:1]; s.expo = 3'h0; end
      2'h1: begin s.mant = {w[16:4], 3'h0}; s.expo = w[3:1]; end
      2'h2: begin s.mant = {w[16:3], 2'h0}; s.expo = {1'b0, w[2:1]}; end
      default: begin s.mant = {w[16:3], 2'h0}; s.expo = {w[0], w[2:1]}; end
    endcase
    return s;
  endfunction

  task automatic cfg(input int i, input logic [2:0] s, input logic ip, input logic [2:0] d, input logic ob,
                     input logic [1:0] f);
    inst_cfg[i] = '{src: s, interp: ip, dly: d, offset_bin: ob, fmt: isf_pkg::isf_fmt_t'(f)};
  endtask

  task automatic watch(input int st, input int n);
    got.delete();
    repeat (n) begin
      @(negedge sys_clk);
      if (sample_out[st].valid === 1'b1) got.push_back(sample_out[st]);
    end
    #21;
  endtask

  task automatic pulse_sync(input logic g, input logic [3:0] ch);
    global_sync_in = g;
    channel_sync_in = ch;
    cyc(3);
    global_sync_in = 1'b0;
    channel_sync_in = 4'h0;
    // armed shows four edges after the pin rises
    cyc(2);
  endtask

  task automatic do_reset;
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset_sync;
    do_reset();
    for (int s = 0; s < 5; s++) check(sample_out[s], '0, "reset sample");
    check(input_armed, 5'h00, "reset armed");
    mode = 2'h1;
    watch(0, 8);
    check(got.size(), 0, "valid before sync");
    pulse_sync(1'b0, 4'h4);
    check(input_armed, 5'h14, "channel sync");
    mode = 2'h0;
    do_reset();
    check(input_armed, 5'h00, "armed cleared by reset");
    pulse_sync(1'b0, 4'h9);
    check(input_armed, 5'h19, "two channel syncs");
    pulse_sync(1'b1, 4'h0);
    check(input_armed, 5'h1f, "global sync");
  endtask

  task automatic t_formats;
    logic [16:0] w;
    w = 17'h1c5a7;
    for (int k = 0; k < 8; k++) begin
      cfg(4, 3'h4 + 3'(k[0]), 1'b0, 3'h0, k[2], k[1:0]);
      test_data = w;
      test_strobe = 1'b1;
      cyc(1);
      test_data = ~w;
      cyc(1);
      test_strobe = 1'b0;
      cyc(1);
      check(sample_out[4], fmt_exp(w, k[1:0], k[2]), "test word format");
      cyc(1);
      check(sample_out[4].valid, 1'b0, "valid one cycle");
      w = w + 17'h0b3d1;
    end
  endtask

  task automatic t_gated;
    int c0;
    c0 = -1;
    cfg(0, 3'h0, 1'b0, 3'h0, 1'b0, 2'h0);
    cfg(1, 3'h3, 1'b0, 3'h0, 1'b0, 2'h0);
    mode = 2'h2;
    cyc(8);
    watch(1, 32);
    check(got.size(), 16, "gated count");
    for (int c = 0; c < 8; c++) if (got.size() > 0 && got[0] === fmt_exp(word(3, c), 2'h0, 1'b0)) c0 = c;
    for (int i = 0; i < got.size(); i++) check(got[i], fmt_exp(word(3, c0 + 2 * i), 2'h0, 1'b0), "gated order");
    mode = 2'h0;
    cyc(4);
  endtask

  task automatic t_mux;
    int d[4] = '{0, 3, 5, 7};
    for (int s = 0; s < 4; s++) cfg(s, 3'h2, 1'b0, 3'(d[s]), 1'b0, 2'h0);
    mode = 2'h3;
    cyc(20);
    for (int s = 0; s < 4; s++) begin
      watch(s, 16);
      check(got.size(), 2, "picks per two groups");
      foreach (got[i]) check(got[i], fmt_exp(word(2, d[s]), 2'h0, 1'b0), "picked channel");
    end
    mode = 2'h0;
    cyc(4);
  endtask

  task automatic t_interp;
    int z;
    z = 0;
    cfg(0, 3'h1, 1'b1, 3'h0, 1'b0, 2'h0);
    mode = 2'h2;
    cyc(8);
    watch(0, 16);
    check(got.size(), 16, "interp valid each clock");
    foreach (got[i]) if (got[i] === 20'h80000) z++;
    check(z, 8, "zero stuffed samples");
    mode = 2'h0;
  endtask

  // -----------------------------------------------------------------
  // clock, main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    test_data = '0;
    test_strobe = 1'b0;
    global_sync_in = 1'b0;
    channel_sync_in = 4'h0;
    inst_cfg = '0;
    mode = 2'h0;
    base = 17'h0a5c3;
    t_reset_sync();
    t_formats();
    t_gated();
    t_mux();
    t_interp();
    close_out();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end
endmodule

`default_nettype wire
